/* dcct_pkg.sv */
// dcct_pkg: register map, field layout, modes and clock sources of the dual counter/capture timer.
// assumes a 32-bit APB master; every register is one aligned word.
package dcct_pkg;

  localparam logic [7:0] ADDR_COUNTER_ONE = 8'h00;
  localparam logic [7:0] ADDR_RELOAD_CAPTURE_FIRST = 8'h04;
  localparam logic [7:0] ADDR_RELOAD_CAPTURE_SECOND = 8'h08;
  localparam logic [7:0] ADDR_COUNTER_TWO = 8'h0c;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_PENDING = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;

  // control register fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_CLKSEL1_LSB = 4;
  localparam int CTL_CLKSEL2_LSB = 8;
  localparam int CTL_PIN_FIRST_ENABLE = 12;
  localparam int CTL_PIN_SECOND_ENABLE = 13;
  localparam int CTL_EDGE_FIRST = 14;
  localparam int CTL_EDGE_SECOND = 15;
  localparam int CTL_PIN_FIRST_LEVEL = 16;
  localparam int CTL_ACCUM_LEVEL = 17;

  // pending / enable bit positions, sources A..D
  localparam int SRC_FIRST = 0;
  localparam int SRC_SECOND = 1;
  localparam int SRC_ONE_UNDERFLOW = 2;
  localparam int SRC_TWO_UNDERFLOW = 3;

  localparam logic [15:0] COUNT_PRESET = 16'hffff;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;

  typedef enum logic [2:0] {
    MODE_PWM = 3'h1,
    MODE_DUAL_CAPTURE = 3'h2,
    MODE_DUAL_TIMER = 3'h3,
    MODE_CAPTURE_TIMER = 3'h4,
    MODE_DUAL_IND_CAPTURE = 3'h5
  } dcct_mode_e;

  typedef enum logic [2:0] {
    CLK_NONE = 3'h0,
    CLK_CORE = 3'h1,
    CLK_EVENT = 3'h2,
    CLK_ACCUM = 3'h3,
    CLK_TICK = 3'h4
  } dcct_clksel_e;

  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] clkSel1;
    logic [2:0] clkSel2;
    logic pinFirstEnable;
    logic pinSecondEnable;
    logic edgeFirst;
    logic edgeSecond;
    logic pinFirstLevel;
    logic accumLevel;
  } dcct_ctl_s;

endpackage

/* dcct_timer.sv */
// dcct_timer: two 16-bit down-counters with reload/capture registers, pins and pending flags.
// assumes an APB master on mclk, an external slow tick already on mclk, pin inputs asynchronous.
//
// Notes on behaviour
// - pwm mode: counter two counts down on its source, flags underflow as D
// - dual capture: pin a/b edges copy counter one into first/second register
// - dual capture with preset: capture counter one, then load it with ffff
// - each capture input has its own rising or falling edge select
// - dual capture: pin a, pin b, counter one underflow set own flags, gated
// - dual capture: counter two is a preloaded timer, flags underflow as D
// - dual capture: event or accumulate source stops counter one
// - dual capture: counter two takes every source, pin b included
// - modes 3/4: counter one reloads from first register, toggles pin a, sets A
// - software chooses pin a starting level before toggling
// - mode 3: counter two reloads from second register, sets D
// - mode 4: counter one runs on any enabled source, counter two on core or tick only
// - mode 4: pin b edge copies counter two into second register, sets B
// - mode 4 with preset: capture counter two, then load it with ffff
// - mode 4: counter two underflow sets D
// - mode 4: pin b sources stop counter two; counter one takes all sources
// - mode 5: pin a captures counter one, pin b captures counter two
// - mode 5: preset touches only the counter of that input
// - mode 5: two captures, two underflows set own flags, each gated
// - mode 5: pin b sources stop either counter
// - underflow is a down count rolling from 0000 to ffff
// - sources A, B, C drive interrupt one; D drives interrupt two
`timescale 1ns/10ps
`default_nettype none

module dcct_timer
  import dcct_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic slowTick,
  input wire logic timerPinFirstIn,
  input wire logic timerPinSecondIn,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic timerPinFirstOut,
  output logic timerPinFirstOe,
  output logic timerIrqOne,
  output logic timerIrqTwo
);

  logic [15:0] counterOne_r;
  logic [15:0] counterTwo_r;
  logic [15:0] reloadCaptureFirst_r;
  logic [15:0] reloadCaptureSecond_r;
  logic [31:0] control_r;
  logic [3:0] pending_r;
  logic [3:0] irqEnable_r;
  logic pwmSecondNext_r;
  logic pinFirstLevel_r;
  logic [2:0] syncFirst_r;
  logic [2:0] syncSecond_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irqOne_r;
  logic irqTwo_r;

  dcct_ctl_s ctl;
  assign ctl.mode = control_r[CTL_MODE_LSB +: 3];
  assign ctl.clkSel1 = control_r[CTL_CLKSEL1_LSB +: 3];
  assign ctl.clkSel2 = control_r[CTL_CLKSEL2_LSB +: 3];
  assign ctl.pinFirstEnable = control_r[CTL_PIN_FIRST_ENABLE];
  assign ctl.pinSecondEnable = control_r[CTL_PIN_SECOND_ENABLE];
  assign ctl.edgeFirst = control_r[CTL_EDGE_FIRST];
  assign ctl.edgeSecond = control_r[CTL_EDGE_SECOND];
  assign ctl.pinFirstLevel = control_r[CTL_PIN_FIRST_LEVEL];
  assign ctl.accumLevel = control_r[CTL_ACCUM_LEVEL];

  // pin sampling: a change counts when stages two and three differ
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      syncFirst_r <= 3'h0;
      syncSecond_r <= 3'h0;
    end else begin
      syncFirst_r <= {syncFirst_r[1:0], timerPinFirstIn};
      syncSecond_r <= {syncSecond_r[1:0], timerPinSecondIn};
    end
  end

  // edge select: 1 = rising, 0 = falling
  wire firstRise = syncFirst_r[1] & ~syncFirst_r[2];
  wire firstFall = ~syncFirst_r[1] & syncFirst_r[2];
  wire secondRise = syncSecond_r[1] & ~syncSecond_r[2];
  wire secondFall = ~syncSecond_r[1] & syncSecond_r[2];
  wire edgeFirst = ctl.edgeFirst ? firstRise : firstFall;
  wire edgeSecond = ctl.edgeSecond ? secondRise : secondFall;
  wire secondLevel = syncSecond_r[2];

  wire modePwm = ctl.mode == MODE_PWM;
  wire modeDualCap = ctl.mode == MODE_DUAL_CAPTURE;
  wire modeDualTmr = ctl.mode == MODE_DUAL_TIMER;
  wire modeCapTmr = ctl.mode == MODE_CAPTURE_TIMER;
  wire modeIndCap = ctl.mode == MODE_DUAL_IND_CAPTURE;

  // pin b is free as a clock source only for a counter that it does not capture into
  wire oneNoPinB = modeDualCap | modeIndCap;
  wire twoNoPinB = modeCapTmr | modeIndCap;

  function automatic logic tickOf(input logic [2:0] sel, input logic blockPin,
                                  input logic evt, input logic lvl, input logic accLvl,
                                  input logic slow);
    logic t;
    t = 1'b0;
    case (sel)
      CLK_CORE: t = 1'b1;
      CLK_EVENT: t = evt & ~blockPin;
      CLK_ACCUM: t = (lvl == accLvl) & ~blockPin;
      CLK_TICK: t = slow;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // counter two in mode 2 takes pin b sources; counter one in mode 4 too
  wire tickOne = tickOf(ctl.clkSel1, oneNoPinB, edgeSecond, secondLevel,
                        ctl.accumLevel, slowTick);
  wire tickTwo = tickOf(ctl.clkSel2, twoNoPinB, edgeSecond, secondLevel,
                        ctl.accumLevel, slowTick);
  wire oneRunning = ctl.clkSel1 != CLK_NONE;
  wire twoRunning = ctl.clkSel2 != CLK_NONE;

  wire underOne = tickOne & (counterOne_r == COUNT_ZERO);
  wire underTwo = tickTwo & (counterTwo_r == COUNT_ZERO);

  // captures are ignored while the time base has no clock
  wire capFirstOne = (modeDualCap | modeIndCap) & edgeFirst & oneRunning;
  wire capSecondOne = modeDualCap & edgeSecond & oneRunning;
  wire capSecondTwo = (modeCapTmr | modeIndCap) & edgeSecond & twoRunning;
  wire presetOne = (capFirstOne & ctl.pinFirstEnable) |
                   (capSecondOne & ctl.pinSecondEnable);
  wire presetTwo = capSecondTwo & ctl.pinSecondEnable;

  wire reloadOneA = modeDualTmr | modeCapTmr | (modePwm & ~pwmSecondNext_r);
  wire reloadOneB = modePwm & pwmSecondNext_r;
  wire reloadTwo = modeDualTmr;

  // apb decode
  // a write lands on the edge that completes the transfer, where pready is seen high
  wire apbWrite = psel & penable & pwrite & pready_r;
  wire apbRead = psel & penable & ~pwrite & ~pready_r;
  wire hitCnt1 = paddr == ADDR_COUNTER_ONE;
  wire hitCrA = paddr == ADDR_RELOAD_CAPTURE_FIRST;
  wire hitCrB = paddr == ADDR_RELOAD_CAPTURE_SECOND;
  wire hitCnt2 = paddr == ADDR_COUNTER_TWO;
  wire hitCtl = paddr == ADDR_CONTROL;
  wire hitPnd = paddr == ADDR_PENDING;
  wire hitIen = paddr == ADDR_IRQ_ENABLE;
  wire hitAny = hitCnt1 | hitCrA | hitCrB | hitCnt2 | hitCtl | hitPnd | hitIen;

  logic [31:0] readMux;
  assign readMux = hitCnt1 ? {16'h0000, counterOne_r} :
                   hitCrA ? {16'h0000, reloadCaptureFirst_r} :
                   hitCrB ? {16'h0000, reloadCaptureSecond_r} :
                   hitCnt2 ? {16'h0000, counterTwo_r} :
                   hitCtl ? control_r :
                   hitPnd ? {28'h0000000, pending_r} :
                   hitIen ? {28'h0000000, irqEnable_r} : 32'h0000_0000;

  // counter one: capture/preset, then reload, then software write, then count
  logic [15:0] counterOne_nxt;
  always_comb begin
    counterOne_nxt = counterOne_r;
    if (presetOne) begin
      counterOne_nxt = COUNT_PRESET;
    end else if (underOne && reloadOneA) begin
      counterOne_nxt = reloadCaptureFirst_r;
    end else if (underOne && reloadOneB) begin
      counterOne_nxt = reloadCaptureSecond_r;
    end else if (apbWrite && hitCnt1) begin
      counterOne_nxt = pwdata[15:0];
    end else if (tickOne) begin
      counterOne_nxt = counterOne_r - 16'h0001;
    end
  end

  logic [15:0] counterTwo_nxt;
  always_comb begin
    counterTwo_nxt = counterTwo_r;
    if (presetTwo) begin
      counterTwo_nxt = COUNT_PRESET;
    end else if (underTwo && reloadTwo) begin
      counterTwo_nxt = reloadCaptureSecond_r;
    end else if (apbWrite && hitCnt2) begin
      counterTwo_nxt = pwdata[15:0];
    end else if (tickTwo) begin
      counterTwo_nxt = counterTwo_r - 16'h0001;
    end
  end

  // capture wins over a software write in the same cycle
  wire [15:0] crA_nxt = capFirstOne ? counterOne_r :
                        (apbWrite && hitCrA) ? pwdata[15:0] : reloadCaptureFirst_r;
  wire [15:0] crB_nxt = capSecondOne ? counterOne_r :
                        capSecondTwo ? counterTwo_r :
                        (apbWrite && hitCrB) ? pwdata[15:0] : reloadCaptureSecond_r;

  // pending sources per mode
  wire setA = capFirstOne | (underOne & (modeDualTmr | modeCapTmr)) |
              (underOne & modePwm & ~pwmSecondNext_r);
  wire setB = capSecondOne | capSecondTwo | (underOne & modePwm & pwmSecondNext_r);
  wire setC = underOne & (modeDualCap | modeIndCap);
  wire setD = underTwo;
  wire [3:0] setVec = {setD, setC, setB, setA};
  // pending is write-one-to-clear; a set in the same cycle wins
  wire [3:0] clrVec = (apbWrite && hitPnd) ? pwdata[3:0] : 4'h0;
  wire [3:0] pending_nxt = setVec | (pending_r & ~clrVec);

  wire pinToggle = underOne & ctl.pinFirstEnable & (modePwm | modeDualTmr | modeCapTmr);
  wire pinDriven = modePwm | modeDualTmr | modeCapTmr;
  wire ctlWrite = apbWrite & hitCtl;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      counterOne_r <= 16'h0000;
      counterTwo_r <= 16'h0000;
      reloadCaptureFirst_r <= 16'h0000;
      reloadCaptureSecond_r <= 16'h0000;
    end else begin
      counterOne_r <= counterOne_nxt;
      counterTwo_r <= counterTwo_nxt;
      reloadCaptureFirst_r <= crA_nxt;
      reloadCaptureSecond_r <= crB_nxt;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      control_r <= CONTROL_RESET;
      irqEnable_r <= 4'h0;
      pending_r <= 4'h0;
    end else begin
      if (ctlWrite) begin
        control_r <= pwdata;
      end
      if (apbWrite && hitIen) begin
        irqEnable_r <= pwdata[3:0];
      end
      pending_r <= pending_nxt;
    end
  end

  // pwm alternation restarts from the first register on mode entry or clock stop
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pwmSecondNext_r <= 1'b0;
    end else if (ctlWrite || !oneRunning) begin
      pwmSecondNext_r <= 1'b0;
    end else if (underOne && modePwm) begin
      pwmSecondNext_r <= ~pwmSecondNext_r;
    end
  end

  // writing control reloads the starting level, so toggling starts where software chose
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pinFirstLevel_r <= 1'b0;
    end else if (ctlWrite) begin
      pinFirstLevel_r <= pwdata[CTL_PIN_FIRST_LEVEL];
    end else if (pinToggle) begin
      pinFirstLevel_r <= ~pinFirstLevel_r;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timerPinFirstOut <= 1'b0;
      timerPinFirstOe <= 1'b0;
      irqOne_r <= 1'b0;
      irqTwo_r <= 1'b0;
    end else begin
      timerPinFirstOut <= pinFirstLevel_r;
      timerPinFirstOe <= pinDriven;
      irqOne_r <= |(pending_r[2:0] & irqEnable_r[2:0]);
      irqTwo_r <= pending_r[SRC_TWO_UNDERFLOW] & irqEnable_r[SRC_TWO_UNDERFLOW];
    end
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~hitAny;
      prdata_r <= apbRead ? readMux : 32'h0000_0000;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign timerIrqOne = irqOne_r;
  assign timerIrqTwo = irqTwo_r;

endmodule // dcct_timer

`default_nettype wire

/* dcct_monitor.sv */
// dcct_monitor: port-level assertions for dcct_timer.
// assumes a bind onto dcct_timer; control and enables are shadowed from apb writes.
`timescale 1ns/10ps
`default_nettype none

module dcct_monitor
  import dcct_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic slowTick,
  input wire logic timerPinFirstIn,
  input wire logic timerPinSecondIn,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timerPinFirstOut,
  input wire logic timerPinFirstOe,
  input wire logic timerIrqOne,
  input wire logic timerIrqTwo
);
  logic [31:0] ctlCopy_r;
  logic [3:0] enCopy_r;
  wire logic wrDone = psel && penable && pready && pwrite;
  wire logic ctlWrite = wrDone && paddr == ADDR_CONTROL;
  wire logic [2:0] mode = ctlCopy_r[2:0];
  wire logic outMode = mode == MODE_PWM || mode == MODE_DUAL_TIMER || mode == MODE_CAPTURE_TIMER;
  wire logic capA = (mode == MODE_DUAL_CAPTURE || mode == MODE_DUAL_IND_CAPTURE) && enCopy_r[0];
  wire logic capB = mode != MODE_PWM && mode != MODE_DUAL_TIMER && enCopy_r[1];
  wire logic [2:0] selB = mode == MODE_DUAL_CAPTURE ? ctlCopy_r[6:4] : ctlCopy_r[10:8];
  // only core and tick clocks count: a stopped counter may legally drop captures
  wire logic runA = ctlCopy_r[6:4] == CLK_CORE || ctlCopy_r[6:4] == CLK_TICK;
  wire logic runB = selB == CLK_CORE || selB == CLK_TICK;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctlCopy_r <= CONTROL_RESET;
      enCopy_r <= 4'h0;
    end else if (ctlWrite) begin
      ctlCopy_r <= pwdata;
    end else if (wrDone && paddr == ADDR_IRQ_ENABLE) begin
      enCopy_r <= pwdata[3:0];
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after access cycle");
  chk_slverr_map: assert property (pready && paddr > ADDR_IRQ_ENABLE |-> pslverr)
    else $error("unmapped access without pslverr");
  chk_oe_mode: assert property (ctlWrite |-> ##2 timerPinFirstOe == outMode)
    else $error("pin a drive enable wrong for mode");
  chk_level_load: assert property (ctlWrite |-> ##2 timerPinFirstOut == ctlCopy_r[16])
    else $error("pin a start level not loaded");
  chk_toggle_cause: assert property ($changed(timerPinFirstOut) |->
      outMode && ctlCopy_r[12] || $past(ctlWrite) || $past(ctlWrite, 2))
    else $error("pin a changed without cause");
  chk_irq_one_gate: assert property (timerIrqOne |-> |$past(enCopy_r[2:0]))
    else $error("interrupt one without enable");
  chk_irq_two_gate: assert property (timerIrqTwo |-> $past(enCopy_r[3]))
    else $error("interrupt two without enable");
  chk_capa_irq: assert property (capA && runA &&
      (ctlCopy_r[14] ? $rose(timerPinFirstIn) : $fell(timerPinFirstIn)) |-> ##[2:8] timerIrqOne)
    else $error("pin a capture gave no interrupt");
  chk_capb_irq: assert property (capB && runB &&
      (ctlCopy_r[15] ? $rose(timerPinSecondIn) : $fell(timerPinSecondIn)) |-> ##[2:8] timerIrqOne)
    else $error("pin b capture gave no interrupt");
endmodule // dcct_monitor

bind dcct_timer dcct_monitor i_dcct_monitor (
  .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .slowTick(slowTick), .timerPinFirstIn(timerPinFirstIn),
  .timerPinSecondIn(timerPinSecondIn), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timerPinFirstOut(timerPinFirstOut), .timerPinFirstOe(timerPinFirstOe),
  .timerIrqOne(timerIrqOne), .timerIrqTwo(timerIrqTwo)
);
`default_nettype wire

/* dcct_pin_model.sv */
// dcct_pin_model: far side of the two timer pins.
// assumes pin a is shared with the timer output, whose drive enable wins.
`timescale 1ns/10ps
`default_nettype none

module dcct_pin_model (
  input wire logic mclk,
  input wire logic pinFirstOe,
  input wire logic pinFirstOut,
  output logic pinFirst,
  output logic pinSecond
);
  logic levelFirst = 1'b0;
  assign pinFirst = pinFirstOe ? pinFirstOut : levelFirst;
  initial pinSecond = 1'b0;

  // one high-then-low pulse; each phase lasts whole core cycles
  task automatic pulse(input logic second, input int width);
    repeat (2) begin
      if (second) begin
        pinSecond <= ~pinSecond;
      end else begin
        levelFirst <= ~levelFirst;
      end
      repeat (width) @(posedge mclk);
    end
  endtask
endmodule // dcct_pin_model
`default_nettype wire

/* tb_top.sv */
// tb_top: self-checking bench for dcct_timer, slowTick used as a hand-stepped clock.
// assumes the one-wait-state apb answer and the control layout of dcct_pkg.
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import dcct_pkg::*;
;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } dcct_row_s;
  logic mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic slowTick = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire logic pinFirst, pinSecond, pready, pslverr, pinOut, pinOe, irqOne, irqTwo;
  wire logic [31:0] prdata;
  int mismatches = 0;
  int compares = 0;
  dcct_row_s rows [0:10] = '{
    '{1'b0, ADDR_COUNTER_ONE, 32'h0, 32'h0, 1'b0},
    '{1'b0, ADDR_RELOAD_CAPTURE_FIRST, 32'h0, 32'h0, 1'b0},
    '{1'b0, ADDR_RELOAD_CAPTURE_SECOND, 32'h0, 32'h0, 1'b0},
    '{1'b0, ADDR_COUNTER_TWO, 32'h0, 32'h0, 1'b0},
    '{1'b0, ADDR_CONTROL, 32'h0, CONTROL_RESET, 1'b0},
    '{1'b0, ADDR_PENDING, 32'h0, 32'h0, 1'b0},
    '{1'b0, ADDR_IRQ_ENABLE, 32'h0, 32'h0, 1'b0},
    '{1'b1, ADDR_RELOAD_CAPTURE_FIRST, 32'h1234_5678, 32'h0, 1'b0},
    '{1'b0, ADDR_RELOAD_CAPTURE_FIRST, 32'h0, 32'h5678, 1'b0},
    '{1'b1, 8'h1c, 32'hffff_ffff, 32'h0, 1'b1},
    '{1'b0, 8'h1c, 32'h0, 32'h0, 1'b1}};

  dcct_timer i_dcct_timer (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .slowTick(slowTick),
    .timerPinFirstIn(pinFirst), .timerPinSecondIn(pinSecond), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timerPinFirstOut(pinOut), .timerPinFirstOe(pinOe),
    .timerIrqOne(irqOne), .timerIrqTwo(irqTwo));
  dcct_pin_model i_dcct_pin_model (.mclk(mclk), .pinFirstOe(pinOe), .pinFirstOut(pinOut),
    .pinFirst(pinFirst), .pinSecond(pinSecond));

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic complete_run;
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; the extra idle edge keeps psel from being set twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk({31'h0, pready}, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask

  // pin a drive enable, pin a level, interrupt two, interrupt one
  task automatic outs(input logic [3:0] exp);
    @(negedge mclk);
    chk({28'h0, pinOe, pinOut, irqTwo, irqOne}, {28'h0, exp});
    @(posedge mclk);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      slowTick <= 1'b1;
      @(posedge mclk);
      slowTick <= 1'b0;
      @(posedge mclk);
    end
  endtask

  function automatic logic [31:0] ctl(logic [2:0] m, logic [2:0] c1, logic [2:0] c2,
                                      logic [5:0] f);
    return {14'h0, f, 1'b0, c2, 1'b0, c1, 1'b0, m};
  endfunction

  initial begin
    #100000;
    mismatches++;
    complete_run();
  end

  initial begin
    logic [31:0] q;
    logic e;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, q, e);
      if (!rows[i].w) chk(q, rows[i].q);
      chk({31'h0, e}, {31'h0, rows[i].e});
    end
    wr(ADDR_IRQ_ENABLE, 32'h7);
    wr(ADDR_COUNTER_ONE, 32'h5);
    wr(ADDR_COUNTER_TWO, 32'h3);
    wr(ADDR_CONTROL, ctl(MODE_DUAL_CAPTURE, CLK_TICK, CLK_TICK, 6'h05));
    i_dcct_pin_model.pulse(1'b0, 3);
    rd(ADDR_RELOAD_CAPTURE_FIRST, 32'h5);
    rd(ADDR_COUNTER_ONE, 32'hffff);
    i_dcct_pin_model.pulse(1'b1, 3);
    rd(ADDR_RELOAD_CAPTURE_SECOND, 32'hffff);
    wr(ADDR_COUNTER_ONE, 32'h0);
    tick(6);
    rd(ADDR_COUNTER_ONE, 32'hfffa);
    rd(ADDR_COUNTER_TWO, 32'hfffd);
    rd(ADDR_PENDING, 32'hf);
    outs(4'h1);
    wr(ADDR_IRQ_ENABLE, 32'hf);
    outs(4'h3);
    wr(ADDR_COUNTER_ONE, 32'h10);
    wr(ADDR_COUNTER_TWO, 32'h10);
    wr(ADDR_CONTROL, ctl(MODE_DUAL_CAPTURE, CLK_EVENT, CLK_EVENT, 6'h08));
    repeat (2) i_dcct_pin_model.pulse(1'b1, 3);
    rd(ADDR_COUNTER_ONE, 32'h10);
    rd(ADDR_COUNTER_TWO, 32'he);
    wr(ADDR_PENDING, 32'hf);
    wr(ADDR_RELOAD_CAPTURE_FIRST, 32'h2);
    wr(ADDR_RELOAD_CAPTURE_SECOND, 32'h1);
    wr(ADDR_COUNTER_ONE, 32'h0);
    wr(ADDR_COUNTER_TWO, 32'h0);
    wr(ADDR_CONTROL, ctl(MODE_DUAL_TIMER, CLK_TICK, CLK_TICK, 6'h11));
    outs(4'hc);
    tick(1);
    rd(ADDR_COUNTER_ONE, 32'h2);
    rd(ADDR_COUNTER_TWO, 32'h1);
    rd(ADDR_PENDING, 32'h9);
    outs(4'hb);
    tick(3);
    outs(4'hf);
    rd(ADDR_COUNTER_TWO, 32'h0);
    wr(ADDR_PENDING, 32'hf);
    wr(ADDR_COUNTER_ONE, 32'h5);
    wr(ADDR_COUNTER_TWO, 32'h7);
    wr(ADDR_CONTROL, ctl(MODE_CAPTURE_TIMER, CLK_EVENT, CLK_TICK, 6'h0a));
    i_dcct_pin_model.pulse(1'b1, 3);
    rd(ADDR_RELOAD_CAPTURE_SECOND, 32'h7);
    rd(ADDR_COUNTER_TWO, 32'hffff);
    rd(ADDR_COUNTER_ONE, 32'h4);
    wr(ADDR_COUNTER_TWO, 32'h0);
    tick(1);
    rd(ADDR_PENDING, 32'ha);
    wr(ADDR_CONTROL, ctl(MODE_CAPTURE_TIMER, CLK_TICK, CLK_ACCUM, 6'h0a));
    tick(2);
    rd(ADDR_COUNTER_TWO, 32'hffff);
    rd(ADDR_COUNTER_ONE, 32'h2);
    wr(ADDR_PENDING, 32'hf);
    wr(ADDR_COUNTER_ONE, 32'h21);
    wr(ADDR_COUNTER_TWO, 32'h42);
    wr(ADDR_CONTROL, ctl(MODE_DUAL_IND_CAPTURE, CLK_TICK, CLK_TICK, 6'h0a));
    i_dcct_pin_model.pulse(1'b0, 3);
    i_dcct_pin_model.pulse(1'b1, 3);
    rd(ADDR_RELOAD_CAPTURE_FIRST, 32'h21);
    rd(ADDR_COUNTER_ONE, 32'h21);
    rd(ADDR_RELOAD_CAPTURE_SECOND, 32'h42);
    rd(ADDR_COUNTER_TWO, 32'hffff);
    rd(ADDR_PENDING, 32'h3);
    wr(ADDR_CONTROL, ctl(MODE_DUAL_IND_CAPTURE, CLK_EVENT, CLK_TICK, 6'h0a));
    tick(1);
    i_dcct_pin_model.pulse(1'b1, 3);
    rd(ADDR_COUNTER_ONE, 32'h21);
    wr(ADDR_PENDING, 32'hf);
    wr(ADDR_COUNTER_TWO, 32'h1);
    wr(ADDR_CONTROL, ctl(MODE_PWM, CLK_NONE, CLK_TICK, 6'h00));
    tick(2);
    rd(ADDR_COUNTER_TWO, 32'hffff);
    outs(4'ha);
    arst_n <= 1'b0;
    outs(4'h0);
    arst_n <= 1'b1;
    @(posedge mclk);
    rd(ADDR_CONTROL, CONTROL_RESET);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
